//--- dme_pkg.sv
// constants and types for the dram/mmio decode and page encryption block
package dme_pkg;
    localparam int PA_W = 52;
    localparam int LIM_LSB = 23;
    localparam int LIM_MSB = 51;
    localparam logic [PA_W-1:0] FOUR_GB = 52'h0_0001_0000_0000;
    // register byte offsets
    localparam logic [7:0] OFF_LOW_LO = 8'h00;
    localparam logic [7:0] OFF_LOW_HI = 8'h04;
    localparam logic [7:0] OFF_HIGH_LO = 8'h08;
    localparam logic [7:0] OFF_HIGH_HI = 8'h0C;
    localparam logic [7:0] OFF_SYSTEM_CONFIG_REG = 8'h10;
    localparam logic [7:0] OFF_CAP_A = 8'h14;
    localparam logic [7:0] OFF_CAP_B = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    // system_config_reg fields
    localparam int LOW_EN_BIT = 20;
    localparam int HIGH_EN_BIT = 21;
    localparam int ENC_EN_BIT = 23;
    localparam logic [31:0] SYSTEM_CONFIG_REG_WMASK = 32'h00B0_0000;
    // combined range attribute fields
    localparam int ATTR_WR_BIT = 3;
    localparam int ATTR_RD_BIT = 4;
    localparam logic [2:0] TYPE_UC = 3'h0;
    // capability fields
    localparam int CAP_SUPPORT_BIT = 0;
    localparam int CAP_COHERENT_BIT = 10;
    localparam int CAP_POS_LSB = 0;
    localparam int CAP_RED_LSB = 6;
    // status fields
    localparam int ST_KEY_BIT = 0;
    localparam int ST_MCE_BIT = 1;
    localparam int ST_PF_BIT = 2;
    localparam int ST_DRAM_BIT = 3;
    // ahb and boot key
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [15:0] KEY_SETTLE_CYC = 16'h0100;
    localparam logic [127:0] KEY_SEED = 128'h0000_0000_0000_0000_0000_0000_0000_0001;
    typedef enum logic [1:0] {
        DME_KS_IDLE = 2'b00,
        DME_KS_GATHER = 2'b01,
        DME_KS_READY = 2'b11
    } dme_key_state_t;
endpackage

//--- dme_decode.sv
// dram/mmio routing by memory limits, range attributes and page encryption
//
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module dme_decode
    import dme_pkg::*;
#(
    parameter int CBIT_POS = 47,
    parameter int PHYS_W = 48,
    parameter int PA_REDUCE = 5,
    parameter bit COHERENT = 1'b0,
    parameter int KEY_W = 128
) (
    input wire logic hclk, // core clock
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // low in reset, then always ready
    output logic hresp, // always okay
    output logic [31:0] hrdata, // read data
    input wire logic req_valid, // access request strobe
    input wire logic [PA_W-1:0] req_addr, // translated address incl. attribute bit
    input wire logic req_write, // write access
    input wire logic req_table_fetch, // page table fetch
    input wire logic req_first_level, // first-level pointer table fetch
    input wire logic req_pae, // physical_extension_flag
    input wire logic req_paging, // paging enabled
    input wire logic req_legacy, // 32-bit extended paging mode
    input wire logic fix_hit, // range_type_registers hit
    input wire logic [4:0] fix_attr, // read_to_dram, write_to_dram, type
    input wire logic entropy_in, // noise source bit
    output logic rsp_valid, // result strobe
    output logic rsp_to_dram, // route to system memory
    output logic [2:0] rsp_mem_type, // memory type
    output logic rsp_encrypt, // encrypt write data
    output logic rsp_decrypt, // decrypt read data
    output logic rsp_page_fault, // reserved bit fault
    output logic rsp_machine_check, // encrypted mmio access
    output logic [PA_W-1:0] rsp_addr, // masked address
    output logic [KEY_W-1:0] crypt_key, // key to cipher engine
    output logic key_valid // key ready
);
    localparam int RED_W = PHYS_W - PA_REDUCE;
    localparam logic [PA_W-1:0] RED_MASK = {PA_W{1'b1}} >> (PA_W - RED_W);
    localparam logic [PA_W-1:0] CBIT_MASK = PA_W'(1) << CBIT_POS;
    localparam bit CBIT_UPPER = (CBIT_POS >= 32);

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // unsigned compare against a limit, low bits as zero
    function automatic logic lim_below(input logic [PA_W-1:0] a, input logic [63:0] lim);
        logic [PA_W-1:0] l;
        l = '0;
        l[LIM_MSB:LIM_LSB] = lim[LIM_MSB:LIM_LSB];
        return a < l;
    endfunction

    logic [63:0] low_dram_limit_reg;
    logic [63:0] high_dram_limit_reg;
    logic [31:0] system_config_reg;
    logic [31:0] status_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [KEY_W-1:0] lfsr_reg;
    logic [15:0] key_cnt_reg;
    dme_key_state_t key_state_reg;

    logic low_limit_enable;
    logic high_limit_enable;
    logic encryption_feature_enable;
    assign low_limit_enable = system_config_reg[LOW_EN_BIT];
    assign high_limit_enable = system_config_reg[HIGH_EN_BIT];
    assign encryption_feature_enable = system_config_reg[ENC_EN_BIT];

    // ---------------- bus slave ----------------
    logic ap_take;
    assign ap_take = hsel && hready && htrans[1];

    function automatic logic [31:0] rd_mux(input logic [7:0] off);
        logic [31:0] v;
        v = RESET_WORD;
        case (off)
            OFF_LOW_LO: v = low_dram_limit_reg[31:0];
            OFF_LOW_HI: v = low_dram_limit_reg[63:32];
            OFF_HIGH_LO: v = high_dram_limit_reg[31:0];
            OFF_HIGH_HI: v = high_dram_limit_reg[63:32];
            OFF_SYSTEM_CONFIG_REG: v = system_config_reg;
            OFF_CAP_A: begin
                v[CAP_SUPPORT_BIT] = 1'b1;
                v[CAP_COHERENT_BIT] = COHERENT;
            end
            OFF_CAP_B: begin
                v[CAP_POS_LSB +: 6] = 6'(CBIT_POS);
                v[CAP_RED_LSB +: 6] = 6'(PA_REDUCE);
            end
            OFF_STATUS: v = status_reg;
            default: v = RESET_WORD;
        endcase
        return v;
    endfunction

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else if (hready) begin
            wr_pend_reg <= ap_take && hwrite && (hsize == HSIZE_WORD);
            wr_addr_reg <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= RESET_WORD;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (ap_take && !hwrite) begin
                hrdata <= rd_mux(haddr[7:0]);
            end
        end
    end

    // key has no bus path at all
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_dram_limit_reg <= {RESET_WORD, RESET_WORD};
            high_dram_limit_reg <= {RESET_WORD, RESET_WORD};
            system_config_reg <= RESET_WORD;
        end else if (wr_pend_reg) begin
            case (wr_addr_reg)
                OFF_LOW_LO: low_dram_limit_reg[31:0] <= hwdata;
                OFF_LOW_HI: low_dram_limit_reg[63:32] <= hwdata;
                OFF_HIGH_LO: high_dram_limit_reg[31:0] <= hwdata;
                OFF_HIGH_HI: high_dram_limit_reg[63:32] <= hwdata;
                OFF_SYSTEM_CONFIG_REG: system_config_reg <= hwdata & SYSTEM_CONFIG_REG_WMASK;
                default: ;
            endcase
        end
    end

    cfg_write_a: assert property (wr_pend_reg && wr_addr_reg == OFF_SYSTEM_CONFIG_REG
        |=> system_config_reg == ($past(hwdata) & SYSTEM_CONFIG_REG_WMASK))
        else $error("config write reached other bits");
    cap_read_a: assert property (ap_take && !hwrite && haddr[7:0] == OFF_CAP_A
        |=> hrdata[CAP_SUPPORT_BIT] && hrdata[CAP_COHERENT_BIT] == COHERENT)
        else $error("capability word wrong");

    // ---------------- boot key ----------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            key_state_reg <= DME_KS_IDLE;
            key_cnt_reg <= 16'h0000;
            lfsr_reg <= KEY_W'(KEY_SEED);
            crypt_key <= '0;
            key_valid <= 1'b0;
        end else begin
            lfsr_reg <= {lfsr_reg[KEY_W-2:0], lfsr_reg[KEY_W-1] ^ lfsr_reg[KEY_W-3]
                         ^ lfsr_reg[KEY_W-28] ^ lfsr_reg[KEY_W-30] ^ entropy_in};
            case (key_state_reg)
                DME_KS_IDLE: key_state_reg <= DME_KS_GATHER;
                DME_KS_GATHER: begin
                    key_cnt_reg <= key_cnt_reg + 16'h0001;
                    if (key_cnt_reg == KEY_SETTLE_CYC) begin
                        crypt_key <= lfsr_reg;
                        key_valid <= 1'b1;
                        key_state_reg <= DME_KS_READY;
                    end
                end
                DME_KS_READY: key_state_reg <= DME_KS_READY;
                default: key_state_reg <= DME_KS_IDLE;
            endcase
        end
    end

    key_stay_a: assert property (key_valid |=> key_valid && key_state_reg == DME_KS_READY)
        else $error("boot key dropped");
    key_time_a: assert property ($rose(key_valid) |-> $past(key_cnt_reg) == KEY_SETTLE_CYC)
        else $error("boot key captured at wrong count");

    // ---------------- access decode ----------------
    logic enc_active;
    logic [PA_W-1:0] pa;
    logic resv_bad;
    logic cbit;
    logic lim_dram;
    logic to_dram;
    logic [2:0] mem_type;

    always_comb begin
        enc_active = encryption_feature_enable && req_pae && req_paging;
        pa = encryption_feature_enable ? (req_addr & RED_MASK & ~CBIT_MASK) : req_addr;
        resv_bad = encryption_feature_enable && (|(req_addr & ~RED_MASK & ~CBIT_MASK));
        cbit = enc_active && req_addr[CBIT_POS];
        if (req_legacy && req_table_fetch && req_first_level && CBIT_UPPER) begin
            cbit = 1'b0;
        end
        if (pa < FOUR_GB) begin
            lim_dram = low_limit_enable && lim_below(pa, low_dram_limit_reg);
        end else begin
            lim_dram = high_limit_enable && lim_below(pa, high_dram_limit_reg);
        end
        if (fix_hit) begin
            to_dram = req_write ? fix_attr[ATTR_WR_BIT] : fix_attr[ATTR_RD_BIT];
            mem_type = fix_attr[2:0];
        end else begin
            to_dram = lim_dram;
            mem_type = TYPE_UC;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rsp_valid <= 1'b0;
            rsp_to_dram <= 1'b0;
            rsp_mem_type <= TYPE_UC;
            rsp_encrypt <= 1'b0;
            rsp_decrypt <= 1'b0;
            rsp_page_fault <= 1'b0;
            rsp_machine_check <= 1'b0;
            rsp_addr <= '0;
        end else begin
            rsp_valid <= req_valid;
            if (req_valid) begin
                rsp_to_dram <= to_dram;
                rsp_mem_type <= mem_type;
                rsp_addr <= pa;
                rsp_page_fault <= resv_bad;
                rsp_machine_check <= cbit && !to_dram && !resv_bad;
                rsp_encrypt <= cbit && to_dram && !resv_bad && req_write;
                rsp_decrypt <= cbit && to_dram && !resv_bad && !req_write;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_reg <= RESET_WORD;
        end else begin
            status_reg[ST_KEY_BIT] <= key_valid;
            if (rsp_valid) begin
                status_reg[ST_MCE_BIT] <= rsp_machine_check;
                status_reg[ST_PF_BIT] <= rsp_page_fault;
                status_reg[ST_DRAM_BIT] <= rsp_to_dram;
            end
        end
    end

    // ---------------- checks ----------------

    logic plain_req;
    assign plain_req = req_valid && !fix_hit && !encryption_feature_enable;

    low_route_a: assert property (plain_req && low_limit_enable && req_addr < FOUR_GB
        && lim_below(req_addr, low_dram_limit_reg) |=> rsp_valid && rsp_to_dram)
        else $error("low region not routed to memory");
    low_mmio_a: assert property (plain_req && req_addr < FOUR_GB
        && !lim_below(req_addr, low_dram_limit_reg) |=> !rsp_to_dram)
        else $error("low mmio region routed to memory");
    high_route_a: assert property (plain_req && high_limit_enable && req_addr >= FOUR_GB
        && lim_below(req_addr, high_dram_limit_reg) |=> rsp_to_dram)
        else $error("high region not routed to memory");
    high_mmio_a: assert property (plain_req && req_addr >= FOUR_GB && !high_limit_enable
        |=> !rsp_to_dram)
        else $error("disabled high limit still routes to memory");
    io_default_a: assert property (plain_req && !low_limit_enable && !high_limit_enable
        |=> !rsp_to_dram)
        else $error("disabled limits did not default to mmio");
    attr_dir_a: assert property (req_valid && fix_hit
        |=> rsp_to_dram == $past(req_write ? fix_attr[ATTR_WR_BIT] : fix_attr[ATTR_RD_BIT])
            && rsp_mem_type == $past(fix_attr[2:0]))
        else $error("attribute direction or type wrong");
    enc_mode_a: assert property (req_valid && !(req_pae && req_paging) && !resv_bad
        |=> !rsp_encrypt && !rsp_decrypt && !rsp_machine_check)
        else $error("encryption applied outside paging mode");
    mmio_check_a: assert property (rsp_valid && rsp_machine_check
        |-> !rsp_to_dram && $past(req_addr[CBIT_POS]) && $past(encryption_feature_enable))
        else $error("machine check without encrypted mmio cause");
    resv_fault_a: assert property (req_valid && resv_bad
        |=> rsp_page_fault && !rsp_encrypt && !rsp_decrypt)
        else $error("reserved bits did not fault");
    mask_addr_a: assert property (rsp_valid && $past(encryption_feature_enable)
        |-> (rsp_addr & ~RED_MASK) == '0)
        else $error("attribute bit left in range check address");
    key_hold_a: assert property (key_valid && $past(key_valid) |-> $stable(crypt_key))
        else $error("boot key changed after capture");

    high_top_a: assert property (plain_req && high_limit_enable && req_addr >= FOUR_GB
        && !lim_below(req_addr, high_dram_limit_reg)
        |=> rsp_valid && !rsp_to_dram)
        else $error("high top routed to memory");
    low_off_a: assert property (plain_req && req_addr < FOUR_GB
        && !low_limit_enable
        |=> rsp_valid && !rsp_to_dram)
        else $error("disabled low limit routes to memory");
    low_bits_a: assert property (plain_req && low_limit_enable && req_addr < FOUR_GB
        && req_addr[LIM_MSB:LIM_LSB] < low_dram_limit_reg[LIM_MSB:LIM_LSB]
        |=> rsp_to_dram)
        else $error("low limit field compare wrong");
    high_bits_a: assert property (plain_req && high_limit_enable && req_addr >= FOUR_GB
        && req_addr[LIM_MSB:LIM_LSB] >= high_dram_limit_reg[LIM_MSB:LIM_LSB]
        |=> !rsp_to_dram)
        else $error("high limit field compare wrong");
    type_uc_a: assert property (plain_req
        |=> rsp_mem_type == TYPE_UC)
        else $error("unmatched access not uncached");

    enc_off_a: assert property (req_valid && !encryption_feature_enable
        |=> !rsp_encrypt && !rsp_decrypt
            && !rsp_machine_check && !rsp_page_fault)
        else $error("encryption effect while disabled");
    plain_page_a: assert property (req_valid && !req_addr[CBIT_POS]
        |=> !rsp_encrypt && !rsp_decrypt
            && !rsp_machine_check)
        else $error("plain page treated as encrypted");
    enc_data_a: assert property (req_valid && enc_active && req_addr[CBIT_POS]
        && !req_legacy && !resv_bad && to_dram
        |=> rsp_encrypt == $past(req_write) && rsp_decrypt == !$past(req_write))
        else $error("encrypted page data not ciphered");
    table_fetch_a: assert property (req_valid && req_table_fetch && !req_write && enc_active
        && req_addr[CBIT_POS] && !req_first_level && !resv_bad && to_dram
        |=> rsp_decrypt)
        else $error("encrypted table fetch not decrypted");
    legacy_ptr_a: assert property (req_valid && CBIT_UPPER && req_legacy
        && req_table_fetch && req_first_level
        |=> !rsp_encrypt && !rsp_decrypt && !rsp_machine_check)
        else $error("pointer table fetched encrypted");
    mce_set_a: assert property (req_valid && enc_active && req_addr[CBIT_POS]
        && !req_legacy && !resv_bad && !to_dram
        |=> rsp_machine_check)
        else $error("encrypted mmio without machine check");

    status_copy_a: assert property (rsp_valid
        |=> status_reg[ST_MCE_BIT] == $past(rsp_machine_check)
            && status_reg[ST_PF_BIT] == $past(rsp_page_fault))
        else $error("status lost last result");

    enc_write_c: cover property (req_valid && req_write ##1 rsp_encrypt);
    dec_read_c: cover property (req_valid && !req_write ##1 rsp_decrypt);
    mce_c: cover property (rsp_machine_check);
    shadow_c: cover property (req_valid && fix_hit && fix_attr[ATTR_WR_BIT] && !fix_attr[ATTR_RD_BIT]);
    shadow_read_c: cover property (req_valid && fix_hit && !fix_attr[ATTR_WR_BIT] && fix_attr[ATTR_RD_BIT]);
endmodule

//--- dme_cpu_model.sv
// processor-side requester model: paging and load/store access path
`timescale 1ns/10ps
module dme_cpu_model
    import dme_pkg::*;
(
    input wire logic hclk, // core clock
    output logic req_valid, // request strobe
    output logic [PA_W-1:0] req_addr, // address with attribute bit
    output logic req_write, // write access
    output logic req_table_fetch, // table fetch
    output logic req_first_level, // first-level pointer table fetch
    output logic req_pae, // physical_extension_flag
    output logic req_paging, // paging on
    output logic req_legacy, // 32-bit extended paging
    output logic fix_hit, // range attribute hit
    output logic [4:0] fix_attr, // range attribute
    output logic entropy_in // noise bit
);
    initial begin
        {req_valid, req_write, req_table_fetch, req_first_level, req_pae, req_paging, req_legacy, fix_hit} = '0;
        req_addr = '0;
        fix_attr = '0;
    end
    always @(posedge hclk) begin
        entropy_in <= 1'($urandom);
    end
    // one request per call, fields f = {write, table, first, pae, paging, legacy, hit}
    task automatic send(input logic [PA_W-1:0] a, input logic [6:0] f, input logic [4:0] at);
        req_valid <= 1'b1;
        req_addr <= a;
        {req_write, req_table_fetch, req_first_level, req_pae, req_paging, req_legacy, fix_hit} <= f;
        fix_attr <= at;
        @(posedge hclk);
    endtask
    // released lines never keep their last value
    task automatic idle();
        req_valid <= 1'b0;
        req_addr <= ~req_addr;
        {req_write, req_table_fetch, req_first_level, req_pae, req_paging, req_legacy, fix_hit} <=
            ~{req_write, req_table_fetch, req_first_level, req_pae, req_paging, req_legacy, fix_hit};
        fix_attr <= ~fix_attr;
        @(posedge hclk);
    endtask
endmodule

//--- dme_decode_tb.sv
// self-checking bench for the dram/mmio decode and page encryption block
`timescale 1ns/10ps
module dme_decode_tb;
    import dme_pkg::*;
    logic hclk = 1'b0;
    logic hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize, rsp_mem_type;
    logic req_valid, req_write, req_table_fetch, req_first_level, req_pae, req_paging, req_legacy, fix_hit, entropy_in;
    logic [PA_W-1:0] req_addr, rsp_addr, a;
    logic [4:0] fix_attr;
    logic rsp_valid, rsp_to_dram, rsp_encrypt, rsp_decrypt, rsp_page_fault, rsp_machine_check, key_valid, pv;
    logic [127:0] crypt_key, key_save;
    logic [63:0] lo_lim, hi_lim;
    logic [31:0] cfg, r;
    logic [59:0] last;
    logic [59:0] expq[$];
    logic key_ok;
    int n_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    int n;
    logic [51:0] bnd [8] = '{52'h0, 52'h7FFF_FFFF, 52'h8000_0000, 52'hFFFF_FFFF, 52'h1_0000_0000,
        52'h1_FFFF_FFFF, 52'h2_0000_0000, 52'hF_FFFF_FFFF_FFFF};
    logic [6:0] encf [7] = '{7'b1001100, 7'b0001100, 7'b0101100, 7'b1000100, 7'b1001000, 7'b0111110, 7'b0001110};
    logic [51:0] enca [3] = '{52'h0_8000_0000_1000, 52'h0_8000_9000_0000, 52'h4_8000_0000_1000};

    always #25 hclk = ~hclk;
    assign hready = hreadyout;

    dme_decode u_dme_decode (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .req_valid(req_valid), .req_addr(req_addr), .req_write(req_write),
        .req_table_fetch(req_table_fetch), .req_first_level(req_first_level), .req_pae(req_pae),
        .req_paging(req_paging), .req_legacy(req_legacy), .fix_hit(fix_hit), .fix_attr(fix_attr),
        .entropy_in(entropy_in), .rsp_valid(rsp_valid), .rsp_to_dram(rsp_to_dram), .rsp_mem_type(rsp_mem_type),
        .rsp_encrypt(rsp_encrypt), .rsp_decrypt(rsp_decrypt), .rsp_page_fault(rsp_page_fault),
        .rsp_machine_check(rsp_machine_check), .rsp_addr(rsp_addr), .crypt_key(crypt_key), .key_valid(key_valid));

    dme_cpu_model u_dme_cpu_model (.hclk(hclk), .req_valid(req_valid), .req_addr(req_addr), .req_write(req_write),
        .req_table_fetch(req_table_fetch), .req_first_level(req_first_level), .req_pae(req_pae),
        .req_paging(req_paging), .req_legacy(req_legacy), .fix_hit(fix_hit), .fix_attr(fix_attr),
        .entropy_in(entropy_in));

    task automatic wrap_up();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // reference decision: {to_dram, type, encrypt, decrypt, fault, mce, address}
    function automatic logic [59:0] model(logic [51:0] ad, logic [6:0] f, logic [4:0] at);
        logic [51:0] m;
        logic pf, c, d;
        m = cfg[23] ? (ad & 52'h7FF_FFFF_FFFF) : ad;
        pf = cfg[23] && ((ad[51:43] & 9'h1EF) != 9'h0);
        c = cfg[23] && f[3] && f[2] && ad[47] && !(f[1] && f[4] && f[5]) && !pf;
        if (f[0])
            d = f[6] ? at[3] : at[4];
        else if (m < FOUR_GB)
            d = cfg[20] && m < {lo_lim[51:23], 23'h0};
        else
            d = cfg[21] && m < {hi_lim[51:23], 23'h0};
        return {d, f[0] ? at[2:0] : TYPE_UC, c && d && f[6], c && d && !f[6], pf, c && !d, m};
    endfunction

    function automatic logic [31:0] reg_exp(logic [7:0] o);
        case (o)
            OFF_LOW_LO: return lo_lim[31:0];
            OFF_LOW_HI: return lo_lim[63:32];
            OFF_HIGH_LO: return hi_lim[31:0];
            OFF_HIGH_HI: return hi_lim[63:32];
            OFF_SYSTEM_CONFIG_REG: return cfg;
            OFF_CAP_A: return 32'h0000_0001;
            OFF_CAP_B: return 32'h0000_016F;
            OFF_STATUS: return {28'h0, last[59], last[53], last[52], key_ok};
            default: return RESET_WORD;
        endcase
    endfunction

    // single AHB-Lite transfer, address phase then data phase
    task automatic bus(input logic w, input logic [7:0] o, input logic [31:0] wd, input logic [2:0] sz,
        output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, o};
        hwrite <= w;
        hsize <= sz;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] o, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, o, d, HSIZE_WORD, x);
        case (o)
            OFF_LOW_LO: lo_lim[31:0] = d;
            OFF_LOW_HI: lo_lim[63:32] = d;
            OFF_HIGH_LO: hi_lim[31:0] = d;
            OFF_HIGH_HI: hi_lim[63:32] = d;
            OFF_SYSTEM_CONFIG_REG: cfg = d & SYSTEM_CONFIG_REG_WMASK;
            default: ;
        endcase
    endtask

    task automatic rd(input logic [7:0] o);
        logic [31:0] x;
        bus(1'b0, o, 32'h0, HSIZE_WORD, x);
        check({32'h0, x}, {32'h0, reg_exp(o)});
    endtask

    task automatic req(input logic [51:0] ad, input logic [6:0] f, input logic [4:0] at);
        last = model(ad, f, at);
        expq.push_back(last);
        u_dme_cpu_model.send(ad, f, at);
    endtask

    // every answer against the reference, one cycle after its request
    always @(posedge hclk) begin
        if (hresetn === 1'b1)
            check({63'h0, rsp_valid}, {63'h0, pv});
        if (rsp_valid === 1'b1 && expq.size() == 0)
            check(64'h1, 64'h0);
        else if (rsp_valid === 1'b1)
            check({rsp_to_dram, rsp_mem_type, rsp_encrypt, rsp_decrypt, rsp_page_fault, rsp_machine_check,
                rsp_addr}, expq.pop_front());
        pv = req_valid;
    end

    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        haddr = 32'h0;
        hwdata = 32'h0;
        lo_lim = '0;
        hi_lim = '0;
        cfg = '0;
        last = '0;
        key_ok = 1'b0;
        pv = 1'b0;
        void'($urandom(32'hF80A7D5B));
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int o = 0; o <= 32; o += 4) rd(8'(o));
        n = 0;
        while (key_valid !== 1'b1 && n < 400) begin
            @(posedge hclk);
            n++;
        end
        check({63'h0, key_valid}, 64'h1);
        key_ok = 1'b1;
        key_save = crypt_key;
        rd(OFF_STATUS);
        wr(OFF_SYSTEM_CONFIG_REG, 32'hFFFF_FFFF);
        rd(OFF_SYSTEM_CONFIG_REG);
        wr(OFF_LOW_LO, 32'h8012_3456);
        wr(OFF_LOW_HI, 32'hFFF0_0000);
        wr(OFF_HIGH_LO, 32'h007F_FFFF);
        wr(OFF_HIGH_HI, 32'hFFF0_0002);
        for (int o = 0; o < 16; o += 4) rd(8'(o));
        for (int c = 0; c < 4; c++) begin
            wr(OFF_SYSTEM_CONFIG_REG, 32'(c) << 20);
            for (int i = 0; i < 16; i++) req(bnd[i % 8], {i[3], 6'b001100}, 5'h0);
            u_dme_cpu_model.idle();
        end
        for (int k = 0; k < 64; k++) req(bnd[k % 8], {k[5], 5'b00000, 1'b1}, k[4:0]);
        u_dme_cpu_model.idle();
        // the first two addresses issued below keep the removed upper bits clear, the third sets bit 50
        wr(OFF_SYSTEM_CONFIG_REG, 32'h00B0_0000);
        for (int i = 0; i < 21; i++) req(enca[i / 7], encf[i % 7], 5'h0);
        u_dme_cpu_model.idle();
        rd(OFF_STATUS);
        for (int i = 0; i < 400; i++) begin
            if (i % 50 == 0) begin
                u_dme_cpu_model.idle();
                wr(OFF_SYSTEM_CONFIG_REG, $urandom);
                wr(OFF_LOW_LO, $urandom);
                wr(OFF_HIGH_LO, $urandom);
                wr(OFF_HIGH_HI, $urandom & 32'h0000_000F);
            end
            a = 52'({$urandom, $urandom});
            if ($urandom % 4 != 0)
                a = a & 52'h0_87FF_FFFF_FFFF;
            req(a, 7'($urandom), 5'($urandom));
            if ($urandom % 3 == 0)
                u_dme_cpu_model.idle();
        end
        u_dme_cpu_model.idle();
        bus(1'b1, OFF_LOW_LO, 32'h1234_5678, 3'h0, r);
        rd(OFF_LOW_LO);
        wr(OFF_CAP_A, 32'hFFFF_FFFF);
        wr(8'h20, 32'hFFFF_FFFF);
        for (int o = 20; o <= 32; o += 4) rd(8'(o));
        @(posedge hclk);
        check(64'(expq.size()), 64'h0);
        check({63'h0, hresp}, 64'h0);
        check({63'h0, crypt_key === key_save}, 64'h1);
        wrap_up();
    end
endmodule
